// >>> rtl/posc_pkg.sv
// Constants and types for the power-on strap capture block.
// Assumes a 32-bit APB slave port with 12-bit byte addresses.
package posc_pkg;
  // Strap bus: bit n carries strap line n, bit 0 unused
  localparam int unsigned STRAP_W = 49;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned DATA_W  = 32;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_A = 8'h4a;
  localparam logic [7:0] IDX_B = 8'h4b;
  localparam logic [7:0] IDX_C = 8'h4c;
  localparam logic [7:0] IDX_H = 8'h5f;
  localparam logic [ADDR_W-1:0] ADDR_A = {2'h0, IDX_A, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_B = {2'h0, IDX_B, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_C = {2'h0, IDX_C, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_H = {2'h0, IDX_H, 2'h0};

  // Reset values and write mask
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] C_WR_MASK = 8'h10;

  // Strap line positions
  localparam int unsigned L_MD2  = 2;
  localparam int unsigned L_MD3  = 3;
  localparam int unsigned L_MD4  = 4;
  localparam int unsigned L_MD5  = 5;
  localparam int unsigned L_MD6  = 6;
  localparam int unsigned L_MD7  = 7;
  localparam int unsigned L_MD16 = 16;
  localparam int unsigned L_MD20 = 20;
  localparam int unsigned L_MD23 = 23;
  localparam int unsigned L_MD24 = 24;
  localparam int unsigned L_MD26 = 26;
  localparam int unsigned L_MD40 = 40;
  localparam int unsigned L_MD41 = 41;
  localparam int unsigned L_MD43 = 43;
  localparam int unsigned L_MD44 = 44;
  localparam int unsigned L_MD45 = 45;
  localparam int unsigned L_MD46 = 46;

  // Field positions in the registers
  localparam int unsigned A_RANGE_LO = 6;
  localparam int unsigned A_SYNC     = 5;
  localparam int unsigned A_DIV      = 4;
  localparam int unsigned A_MIR_LO   = 2;
  localparam int unsigned C_TOP      = 5;
  localparam int unsigned C_DOT      = 4;
  localparam int unsigned C_MEM      = 3;
  localparam int unsigned C_HOST     = 2;
  localparam int unsigned C_DIV      = 1;
  localparam int unsigned H_SPD_LO   = 3;

  // Clock range and divisor encodings
  localparam logic [1:0] RANGE_RSVD = 2'h3;
  localparam logic [2:0] DIV_RSVD   = 3'h0;
  localparam logic [2:0] DIV_BY4    = 3'h4;
  localparam logic [2:0] DIV_BY3    = 3'h3;
  localparam logic [2:0] DIV_BY2    = 3'h2;

  typedef enum logic {
    ST_CAPTURE,
    ST_HOLD
  } posc_state_t;
endpackage : posc_pkg

// >>> rtl/posc_apb_slave.sv
// APB register port of the strap capture block.
// Assumes a well-behaved APB master; one wait-free access cycle.
`timescale 1ns/1ns
module posc_apb_slave (
  // Clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // APB
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [posc_pkg::ADDR_W-1:0] paddr,
  output logic      [posc_pkg::DATA_W-1:0] prdata_ff,
  output logic                              pready_ff,
  output logic                              pslverr_ff,
  // Register values
  input  wire logic [7:0]                   rd_a,
  input  wire logic [7:0]                   rd_c,
  input  wire logic [7:0]                   rd_h,
  // Write strobe for the one writable register
  output logic                              wr_c_en
);
  logic setup;
  logic hit;
  logic [7:0] rd_sel;

  assign setup = psel & ~penable;

  always_comb begin
    hit    = 1'b1;
    rd_sel = posc_pkg::REG_RST;
    case (paddr)
      posc_pkg::ADDR_A: rd_sel = rd_a;
      posc_pkg::ADDR_B: rd_sel = posc_pkg::REG_RST;
      posc_pkg::ADDR_C: rd_sel = rd_c;
      posc_pkg::ADDR_H: rd_sel = rd_h;
      default:          hit    = 1'b0;
    endcase
  end

  // Write lands on the completing edge only
  assign wr_c_en = psel & penable & pready_ff & pwrite & (paddr == posc_pkg::ADDR_C);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= (setup & ~pwrite) ? {24'h0, rd_sel} : 32'h0;
      pslverr_ff <= setup & ~hit;
    end
  end
endmodule : posc_apb_slave

// >>> rtl/posc_strap_capture.sv
// Power-on strap capture: latches strap lines and drives clock/bus config.
// Assumes strap lines are stable and pulled until the first pclk edge after presetn rises.
`timescale 1ns/1ns
module posc_strap_capture (
  // Clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [posc_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [posc_pkg::DATA_W-1:0]  pwdata,
  output logic      [posc_pkg::DATA_W-1:0]  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Strap lines and system status
  input  wire logic [posc_pkg::STRAP_W-1:0] strap_line,
  input  wire logic                          clk_same_freq,
  // Configuration outputs
  output logic                               config_valid_ff,
  output logic                               config_reserved_ff,
  output logic      [1:0]                    pci_clk_range_ff,
  output logic      [2:0]                    pci_clk_div_ff,
  output logic                               unified_clk_ff,
  output logic                               dot_clock_oe_ff,
  output logic                               memory_clock_out_oe_ff,
  output logic                               host_clock_oe_ff,
  output logic      [4:0]                    host_clk_speed_ff,
  output logic                               host_pll_en_ff,
  output logic      [1:0]                    host_pll_range_ff,
  output logic                               core_double_rate_ff,
  output logic      [2:0]                    core_dll_tick_ff,
  output logic                               isa_bus_en_ff,
  output logic                               local_bus_en_ff
);
  posc_pkg::posc_state_t state_ff;
  posc_pkg::posc_state_t nxt_state;
  logic [7:0] reg_a_ff;
  logic [7:0] reg_c_ff;
  logic [7:0] reg_h_ff;
  logic [6:0] hw_ff;
  logic [7:0] nxt_reg_c;
  logic       wr_c_en;
  logic       capture;
  logic       hold;
  logic [2:0] nxt_div;

  assign capture = (state_ff == posc_pkg::ST_CAPTURE);
  assign hold    = (state_ff == posc_pkg::ST_HOLD);

  posc_apb_slave u_apb (
    .pclk       (pclk),
    .presetn    (presetn),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .prdata_ff  (prdata),
    .pready_ff  (pready),
    .pslverr_ff (pslverr),
    .rd_a       (reg_a_ff),
    .rd_c       (reg_c_ff),
    .rd_h       (reg_h_ff),
    .wr_c_en    (wr_c_en)
  );

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      posc_pkg::ST_CAPTURE: nxt_state = posc_pkg::ST_HOLD;
      posc_pkg::ST_HOLD:    nxt_state = posc_pkg::ST_HOLD;
      default:              nxt_state = posc_pkg::ST_CAPTURE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= posc_pkg::ST_CAPTURE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Straps are caught by a clocked process after release, never by the reset itself
  // capture register A
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_a_ff <= posc_pkg::REG_RST;
    end else if (capture) begin
      reg_a_ff <= {strap_line[posc_pkg::L_MD7:posc_pkg::L_MD6],
                   strap_line[posc_pkg::L_MD5],
                   strap_line[posc_pkg::L_MD4],
                   strap_line[posc_pkg::L_MD3:posc_pkg::L_MD2],
                   2'h0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_h_ff <= posc_pkg::REG_RST;
    end else if (capture) begin
      reg_h_ff <= {strap_line[posc_pkg::L_MD3:posc_pkg::L_MD2],
                   strap_line[posc_pkg::L_MD26:posc_pkg::L_MD24],
                   3'h0};
    end
  end

  always_comb begin
    nxt_reg_c = reg_c_ff;
    if (capture) begin
      nxt_reg_c = {2'h0, strap_line[posc_pkg::L_MD23],
                   strap_line[posc_pkg::L_MD20:posc_pkg::L_MD16]};
    end else if (wr_c_en) begin
      nxt_reg_c = (reg_c_ff & ~posc_pkg::C_WR_MASK) | (pwdata[7:0] & posc_pkg::C_WR_MASK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_c_ff <= posc_pkg::REG_RST;
    end else begin
      reg_c_ff <= nxt_reg_c;
    end
  end

  // Hardware-only straps, lines 46 down to 40
  // hold until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_ff <= 7'h00;
    end else if (capture) begin
      hw_ff <= strap_line[posc_pkg::L_MD46:posc_pkg::L_MD40];
    end
  end

  always_comb begin
    case ({reg_a_ff[posc_pkg::A_DIV], reg_c_ff[posc_pkg::C_DIV]})
      2'h1:    nxt_div = posc_pkg::DIV_BY4;
      2'h2:    nxt_div = posc_pkg::DIV_BY3;
      2'h3:    nxt_div = posc_pkg::DIV_BY2;
      default: nxt_div = posc_pkg::DIV_RSVD;
    endcase
  end

  // Outputs follow the registers one cycle late; all low until captured
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_valid_ff    <= 1'b0;
      pci_clk_range_ff   <= 2'h0;
      pci_clk_div_ff     <= posc_pkg::DIV_RSVD;
      unified_clk_ff     <= 1'b0;
      config_reserved_ff <= 1'b0;
    end else if (hold) begin
      config_valid_ff  <= 1'b1;
      pci_clk_range_ff <= reg_a_ff[posc_pkg::A_RANGE_LO+1:posc_pkg::A_RANGE_LO];
      pci_clk_div_ff   <= nxt_div;
      unified_clk_ff   <= reg_a_ff[posc_pkg::A_SYNC] & clk_same_freq;
      config_reserved_ff <= (reg_a_ff[7:6] == posc_pkg::RANGE_RSVD) |
                            (nxt_div == posc_pkg::DIV_RSVD) |
                            (hw_ff[6:5] == posc_pkg::RANGE_RSVD);
    end
  end

  // Pad drive enables; the clock muxing itself sits in the pad ring
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dot_clock_oe_ff        <= 1'b0;
      memory_clock_out_oe_ff <= 1'b0;
      host_clock_oe_ff       <= 1'b0;
    end else if (hold) begin
      dot_clock_oe_ff        <= reg_c_ff[posc_pkg::C_DOT];
      memory_clock_out_oe_ff <= reg_c_ff[posc_pkg::C_MEM];
      host_clock_oe_ff       <= reg_c_ff[posc_pkg::C_HOST];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_clk_speed_ff   <= 5'h00;
      host_pll_en_ff      <= 1'b0;
      host_pll_range_ff   <= 2'h0;
      core_double_rate_ff <= 1'b0;
      core_dll_tick_ff    <= 3'h0;
      isa_bus_en_ff       <= 1'b0;
      local_bus_en_ff     <= 1'b0;
    end else if (hold) begin
      host_clk_speed_ff   <= reg_h_ff[7:posc_pkg::H_SPD_LO];
      host_pll_en_ff      <= hw_ff[6:5] != posc_pkg::RANGE_RSVD;
      host_pll_range_ff   <= hw_ff[6:5];
      core_double_rate_ff <= hw_ff[0];
      core_dll_tick_ff    <= hw_ff[3:1];
      isa_bus_en_ff       <= ~hw_ff[4];
      local_bus_en_ff     <= hw_ff[4];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_capture_once: assert property (
    capture |=> hold ##1 hold)
    else $error("capture window did not close");

  a_hold_stable: assert property (
    hold && $past(hold) |-> $stable(reg_a_ff) && $stable(reg_h_ff) && $stable(hw_ff))
    else $error("captured straps changed");

  a_range_capture: assert property (
    capture |=> ##1 pci_clk_range_ff == $past(strap_line[7:6], 2))
    else $error("PCI range not from straps");

  a_unify_clocks: assert property (
    hold && reg_a_ff[5] && clk_same_freq |=> unified_clk_ff)
    else $error("clocks not unified");

  a_pci_divisor: assert property (
    hold && !reg_a_ff[4] && reg_c_ff[1] |=> pci_clk_div_ff == 3'h4)
    else $error("PCI divisor not four");

  a_mirror_bits: assert property (
    reg_a_ff[3:2] == reg_h_ff[7:6] && reg_a_ff[1:0] == 2'h0)
    else $error("mirror bits disagree");

  a_dot_pad: assert property (
    capture |=> ##1 dot_clock_oe_ff == $past(strap_line[20], 2))
    else $error("dot clock pad wrong");

  a_dot_write: assert property (
    hold && wr_c_en |=> reg_c_ff[4] == $past(pwdata[4]) ##1 dot_clock_oe_ff == $past(pwdata[4], 2))
    else $error("dot clock write lost");

  a_mem_pad: assert property (
    hold ##1 hold |-> memory_clock_out_oe_ff == $past(reg_c_ff[3]))
    else $error("memory clock drive wrong");

  a_host_pad: assert property (
    capture |=> ##1 host_clock_oe_ff == $past(strap_line[18], 2))
    else $error("host clock pad wrong");

  a_c_default: assert property (
    capture |=> reg_c_ff == {2'h0, $past(strap_line[23]), $past(strap_line[20:16])})
    else $error("register C default wrong");

  a_speed_code: assert property (
    capture |=> ##1 host_clk_speed_ff == {$past(strap_line[3:2], 2), $past(strap_line[26:24], 2)})
    else $error("speed code wrong");

  a_pll_enable: assert property (
    hold ##1 hold |-> host_pll_en_ff == (host_pll_range_ff != 2'h3))
    else $error("PLL enable mismatch");

  a_core_rate: assert property (
    capture |=> ##1 core_double_rate_ff == $past(strap_line[40], 2))
    else $error("core rate wrong");

  a_bus_exclusive: assert property (
    config_valid_ff |-> isa_bus_en_ff != local_bus_en_ff)
    else $error("both or no bus enabled");

  a_tick_capture: assert property (
    capture |=> ##1 core_dll_tick_ff == $past(strap_line[43:41], 2))
    else $error("DLL tick not from straps");

  a_pll_range: assert property (
    capture |=> ##1 host_pll_range_ff == $past(strap_line[46:45], 2))
    else $error("PLL range not from straps");

  a_bus_select: assert property (
    capture |=> ##1 local_bus_en_ff == $past(strap_line[44], 2))
    else $error("bus select not from strap");

  a_mem_capture: assert property (
    capture |=> ##1 memory_clock_out_oe_ff == $past(strap_line[19], 2))
    else $error("memory clock strap lost");

  a_div_three: assert property (
    hold && reg_a_ff[4] && !reg_c_ff[1] |=> pci_clk_div_ff == 3'h3)
    else $error("PCI divisor not three");

  a_div_two: assert property (
    hold && reg_a_ff[4] && reg_c_ff[1] |=> pci_clk_div_ff == 3'h2)
    else $error("PCI divisor not two");

  a_sync_capture: assert property (
    capture |=> reg_a_ff[5] == $past(strap_line[5]))
    else $error("sync strap not captured");

  a_no_unify: assert property (
    hold && !reg_a_ff[5] |=> !unified_clk_ff)
    else $error("clocks unified without strap");

  a_c_top_zero: assert property (
    reg_c_ff[7:6] == 2'h0)
    else $error("register C top bits set");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held past access");

  a_error_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");

  c_isa: cover property (config_valid_ff && isa_bus_en_ff);
  c_capture: cover property (capture ##1 hold ##1 config_valid_ff);
  c_dot_write: cover property (hold && wr_c_en ##2 dot_clock_oe_ff);
  c_unified: cover property (unified_clk_ff && local_bus_en_ff);
  c_reserved: cover property (config_reserved_ff);
endmodule : posc_strap_capture

// >>> test/posc_board_straps.sv
// Board strap resistor model on the strap lines.
// Assumes the bench supplies the user-defined levels.
`timescale 1ns/1ns
module posc_board_straps (
  // Board settings
  input  wire logic [posc_pkg::STRAP_W-1:0] user_level,
  input  wire logic                         pulls_fitted,
  // Strap lines
  output logic      [posc_pkg::STRAP_W-1:0] strap_line
);
  // Lines with a mandated resistor, and which of them pull up
  localparam logic [48:0] PULL_MASK = 49'h1ee0000e17c00;
  localparam logic [48:0] PULL_UP   = 49'h1440000e17800;

  // user lines pass
  // Unfitted pulls only model a faulty board
  assign strap_line = pulls_fitted ? ((user_level & ~PULL_MASK) | PULL_UP) : user_level;
endmodule : posc_board_straps

// >>> test/power_on_strap_capture_test.sv
// Self-checking bench for the strap capture block.
// Assumes the board model drives the strap lines.
`timescale 1ns/1ns
module power_on_strap_capture_test;
  typedef struct packed {
    logic [48:0] lvl;
    logic        pulls;
    logic        same;
  } posc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, same, pulls, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [48:0] lvl, strap_line, cap;
  logic [1:0]  pci_rng, pll_rng;
  logic [2:0]  pci_div, tick;
  logic [4:0]  speed;
  logic        valid, rsvd, uni, dot_oe, mem_oe, host_oe, pll_en, dbl, isa_en, loc_en;
  logic [24:0] cfg;
  int          n_mismatch, samples_checked;
  posc_row_t   rows [4];

  assign cfg = {valid, rsvd, pci_rng, pci_div, uni, dot_oe, mem_oe, host_oe, speed, pll_en, pll_rng, dbl, tick,
                isa_en, loc_en};

  posc_board_straps posc_board_straps_i (.user_level(lvl), .pulls_fitted(pulls), .strap_line(strap_line));
  posc_strap_capture posc_strap_capture_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .strap_line(strap_line),
    .clk_same_freq(same), .config_valid_ff(valid), .config_reserved_ff(rsvd), .pci_clk_range_ff(pci_rng),
    .pci_clk_div_ff(pci_div), .unified_clk_ff(uni), .dot_clock_oe_ff(dot_oe), .memory_clock_out_oe_ff(mem_oe),
    .host_clock_oe_ff(host_oe), .host_clk_speed_ff(speed), .host_pll_en_ff(pll_en),
    .host_pll_range_ff(pll_rng), .core_double_rate_ff(dbl), .core_dll_tick_ff(tick),
    .isa_bus_en_ff(isa_en), .local_bus_en_ff(loc_en));

  function automatic logic [24:0] exp_cfg(logic [48:0] s, logic sm);
    logic [2:0] d;
    case ({s[4], s[17]})
      2'h1: d = posc_pkg::DIV_BY4;
      2'h2: d = posc_pkg::DIV_BY3;
      2'h3: d = posc_pkg::DIV_BY2;
      default: d = posc_pkg::DIV_RSVD;
    endcase
    return {1'h1, s[7:6] == 2'h3 || d == 3'h0 || s[46:45] == 2'h3, s[7:6], d, s[5] & sm, s[20:18], s[3:2],
            s[26:24], s[46:45] != 2'h3, s[46:45], s[40], s[43:41], ~s[44], s[44]};
  endfunction : exp_cfg

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Called just after a rising edge; leaves one idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      n_mismatch++;
      final_report();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(rd, e);
  endtask : chk_reg

  task automatic do_reset(input posc_row_t r);
    lvl     <= r.lvl;
    pulls   <= r.pulls;
    same    <= r.same;
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk(cfg, 32'h0);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    cap = strap_line;
  endtask : do_reset

  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    {presetn, psel, penable, pwrite, same, pulls} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    lvl = 49'h0;
    n_mismatch = 0;
    samples_checked = 0;
    rows[0] = '{49'h0, 1'h0, 1'h0};
    rows[1] = '{49'h01100071e006c, 1'h1, 1'h1};
    rows[2] = '{49'h0240000080090, 1'h0, 1'h1};
    rows[3] = '{49'h06a00008300f0, 1'h0, 1'h0};
    @(posedge pclk);
    foreach (rows[i]) begin
      do_reset(rows[i]);
      chk(cfg, exp_cfg(cap, rows[i].same));
      chk_reg(posc_pkg::ADDR_A, {24'h0, cap[7:2], 2'h0});
      chk_reg(posc_pkg::ADDR_C, {26'h0, cap[23], cap[20:16]});
      chk_reg(posc_pkg::ADDR_H, {24'h0, cap[3:2], cap[26:24], 3'h0});
    end
    // Software override of the dot clock pad drive enable, both ways
    for (int i = 1; i >= 0; i--) begin
      apb(1'h1, posc_pkg::ADDR_C, {27'h0, i[0], 4'h0});
      chk_reg(posc_pkg::ADDR_C, {26'h0, cap[23], i[0], cap[19:16]});
      chk(dot_oe, i[0]);
    end
    // Writes to read-only and reserved registers are ignored
    apb(1'h1, posc_pkg::ADDR_A, 32'hff);
    apb(1'h1, posc_pkg::ADDR_B, 32'hff);
    apb(1'h1, posc_pkg::ADDR_H, 32'hff);
    chk_reg(posc_pkg::ADDR_A, {24'h0, cap[7:2], 2'h0});
    chk_reg(posc_pkg::ADDR_B, 32'h0);
    chk_reg(posc_pkg::ADDR_H, {24'h0, cap[3:2], cap[26:24], 3'h0});
    apb(1'h0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'h1);
    // Strap lines and clk_same_freq move after capture; outputs other than unified_clk_ff must hold
    lvl   <= ~lvl;
    pulls <= 1'h1;
    same  <= 1'h1;
    repeat (4) @(posedge pclk);
    chk(cfg, exp_cfg(cap, 1'h1));
    chk_reg(posc_pkg::ADDR_C, {26'h0, cap[23], cap[20:16]});
    final_report();
  end
endmodule : power_on_strap_capture_test
